//--- hw/mcd_pkg.sv
// shared constants and types for the memory clock deskew generator
package mcd_pkg;

  // delay steps per core clock period
  localparam int unsigned STEPS       = 128;
  localparam int unsigned STEP_W      = 7;
  localparam logic [6:0]  STEP_ZERO   = 7'h00;
  localparam logic [6:0]  STEP_HALF   = 7'h40;
  localparam logic [6:0]  STEP_LAST   = 7'h7F;
  localparam logic [6:0]  STEP_ONE    = 7'h01;

  // output counts and command width
  localparam int unsigned MEM_CLKS    = 4;
  localparam int unsigned CPU_CLKS    = 3;
  localparam int unsigned CMD_W       = 8;

  // count runs from the launch rise; only the return edge detector adds a step
  localparam logic [6:0]  MEAS_LATENCY = 7'h01;

  // ceiling of the agreement count; the advance is taken on the third equal measurement in a row
  localparam logic [1:0]  LOCK_HITS   = 2'h2;
  localparam logic [1:0]  HITS_ZERO   = 2'h0;
  localparam logic [1:0]  HITS_ONE    = 2'h1;

  // mclk period in ns, one step per mclk cycle
  localparam int unsigned MCLK_PERIOD_NS = 20;

  typedef enum logic [1:0] {
    MCD_WAIT  = 2'b00,
    MCD_COUNT = 2'b01,
    MCD_EVAL  = 2'b10
  } mcd_state_t;

  // clock level for a given step position: high in the first half
  function automatic logic mcd_clk_level(input logic [6:0] pos);
    mcd_clk_level = (pos < STEP_HALF);
  endfunction

  // step position shifted forward by an advance, wrapping at one period
  function automatic logic [6:0] mcd_advance(input logic [6:0] pos,
                                             input logic [6:0] adv);
    logic [7:0] sum;
    sum = {1'b0, pos} + {1'b0, adv};
    mcd_advance = sum[6:0];
  endfunction

endpackage

//--- hw/mcd_rise_det.sv
// rising edge detector for the feedback return input
`timescale 1ns/1ns
module mcd_rise_det (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  // level in, one-cycle pulse out
  input  wire logic level_i,
  output logic      rise_o
);

  logic prev;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev <= 1'b0;
    end else begin
      prev <= level_i;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rise_o <= 1'b0;
    end else begin
      rise_o <= level_i & ~prev;
    end
  end

endmodule // mcd_rise_det

//--- hw/mcd_deskew_dll.sv
// delay-locked memory clock generator with feedback loop measurement
//
// Notes on behaviour
// R1 - four memory clocks from the generator
// R2 - core period split into 128 steps
// R3 - launch feedback clock, count steps to return
// R4 - advance memory clocks by measured loop delay
// R5 - memory command signals stay on core clock
// R6 - advance only memory, cpu, launch clocks
// R7 - keep measuring, hold last valid count
`timescale 1ns/1ns
module mcd_deskew_dll (
  // clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         resetn_i,
  // board feedback loop
  output logic                              fb_launch_o,
  input  wire logic                         fb_return_i,
  // generated clocks
  output logic                              core_clk_o,
  output logic [mcd_pkg::MEM_CLKS-1:0]      mem_clk_o,
  output logic [mcd_pkg::CPU_CLKS-1:0]      cpu_clk_o,
  // memory command path, core-clock timed
  input  wire logic [mcd_pkg::CMD_W-1:0]    mem_cmd_i,
  output logic [mcd_pkg::CMD_W-1:0]         mem_cmd_o,
  // status
  output logic                              locked_o,
  output logic                              meas_miss_o,
  output logic [mcd_pkg::STEP_W-1:0]        advance_o
);

  // step position within the core period; one mclk cycle is one step
  logic [6:0]         phase;
  logic [6:0]         advance;
  logic [6:0]         adv_phase;
  logic               adv_level;
  logic               core_level;
  logic               launch_edge;
  logic               return_rise;

  mcd_pkg::mcd_state_t state;
  mcd_pkg::mcd_state_t next_state;

  logic [6:0]         meas_cnt;
  logic [6:0]         meas_val;
  logic [6:0]         last_meas;
  logic [1:0]         hits;
  logic               meas_done;
  logic               meas_timeout;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= mcd_pkg::STEP_ZERO;
    end else begin
      phase <= phase + mcd_pkg::STEP_ONE; // R2
    end
  end

  // advanced position leads the core position by the held advance
  assign adv_phase   = mcd_pkg::mcd_advance(phase, advance); // R4
  assign adv_level   = mcd_pkg::mcd_clk_level(adv_phase);
  assign core_level  = mcd_pkg::mcd_clk_level(phase);
  assign launch_edge = (adv_phase == mcd_pkg::STEP_ZERO);

  // all clocks pass one register so their relative skew is only the advance
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      core_clk_o <= 1'b0;
    end else begin
      core_clk_o <= core_level;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_clk_o <= '0;
    end else begin
      mem_clk_o <= {mcd_pkg::MEM_CLKS{adv_level}}; // R1 R6
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cpu_clk_o <= '0;
    end else begin
      cpu_clk_o <= {mcd_pkg::CPU_CLKS{adv_level}}; // R6
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fb_launch_o <= 1'b0;
    end else begin
      fb_launch_o <= adv_level; // R3 R6
    end
  end

  // command path sampled at the core rising edge, never at the advanced one
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mem_cmd_o <= '0;
    end else if (phase == mcd_pkg::STEP_ZERO) begin
      mem_cmd_o <= mem_cmd_i; // R5
    end
  end

  mcd_rise_det u_ret_det (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .level_i  (fb_return_i),
    .rise_o   (return_rise)
  );

  assign meas_done    = (state == mcd_pkg::MCD_COUNT) && return_rise;
  assign meas_timeout = (state == mcd_pkg::MCD_COUNT) && !return_rise
                        && (meas_cnt == mcd_pkg::STEP_LAST);

  always_comb begin
    next_state = state;
    case (state)
      mcd_pkg::MCD_WAIT: begin
        if (launch_edge) begin
          next_state = mcd_pkg::MCD_COUNT; // R3
        end
      end
      mcd_pkg::MCD_COUNT: begin
        if (meas_done) begin
          next_state = mcd_pkg::MCD_EVAL;
        end else if (meas_timeout) begin
          next_state = mcd_pkg::MCD_WAIT;
        end
      end
      mcd_pkg::MCD_EVAL: begin
        next_state = mcd_pkg::MCD_WAIT; // R7
      end
      default: begin
        next_state = mcd_pkg::MCD_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= mcd_pkg::MCD_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // step counter, started by the launch edge
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_cnt <= mcd_pkg::STEP_ZERO;
    end else if (state == mcd_pkg::MCD_WAIT) begin
      meas_cnt <= mcd_pkg::STEP_ZERO;
    end else if (state == mcd_pkg::MCD_COUNT && !return_rise) begin
      meas_cnt <= meas_cnt + mcd_pkg::STEP_ONE; // R3
    end
  end

  // loop delay with the internal pipeline taken out, floored at zero
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_val <= mcd_pkg::STEP_ZERO;
    end else if (meas_done) begin
      if (meas_cnt > mcd_pkg::MEAS_LATENCY) begin
        meas_val <= meas_cnt - mcd_pkg::MEAS_LATENCY; // R3
      end else begin
        meas_val <= mcd_pkg::STEP_ZERO;
      end
    end
  end

  // agreement filter: one noisy return cannot jerk the clocks
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hits <= mcd_pkg::HITS_ZERO;
    end else if (meas_timeout) begin
      hits <= mcd_pkg::HITS_ZERO;
    end else if (state == mcd_pkg::MCD_EVAL) begin
      if (meas_val != last_meas) begin
        hits <= mcd_pkg::HITS_ZERO;
      end else if (hits != mcd_pkg::LOCK_HITS) begin
        hits <= hits + mcd_pkg::HITS_ONE;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      last_meas <= mcd_pkg::STEP_ZERO;
    end else if (state == mcd_pkg::MCD_EVAL) begin
      last_meas <= meas_val;
    end
  end

  // advance changes only on an agreed measurement; otherwise held
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      advance <= mcd_pkg::STEP_ZERO;
    end else if (state == mcd_pkg::MCD_EVAL && meas_val == last_meas
                 && hits >= mcd_pkg::HITS_ONE) begin
      advance <= meas_val; // R4 R7
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      locked_o <= 1'b0;
    end else if (state == mcd_pkg::MCD_EVAL && meas_val == last_meas
                 && hits >= mcd_pkg::HITS_ONE) begin
      locked_o <= 1'b1; // R7
    end
  end

  // miss flag tracks the latest attempt; lock and advance survive a miss
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meas_miss_o <= 1'b0;
    end else if (meas_timeout) begin
      meas_miss_o <= 1'b1; // R7
    end else if (meas_done) begin
      meas_miss_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      advance_o <= mcd_pkg::STEP_ZERO;
    end else begin
      advance_o <= advance;
    end
  end

endmodule // mcd_deskew_dll

//--- verif/mcd_fb_loop.sv
// board feedback trace model: launch clock returns after a set delay
`timescale 1ns/1ns
module mcd_fb_loop (
  // step clock
  input  wire logic       mclk_i,
  // loop
  input  wire logic       launch_i,
  input  wire logic [6:0] delay_i,
  output logic            ret_o
);
  logic [127:0] hist = '0;
  always_ff @(posedge mclk_i) begin
    hist <= {hist[126:0], launch_i};
  end
  // zero delay models a broken trace held low by its termination
  assign ret_o = (delay_i == 7'h00) ? 1'b0 : hist[delay_i - 7'h01];
endmodule // mcd_fb_loop

//--- verif/mcd_deskew_chk.sv
// port assertions for the memory clock deskew generator
`timescale 1ns/1ns
module mcd_deskew_chk (
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       resetn_i,
  // watched ports
  input wire logic       fb_launch_o,
  input wire logic       core_clk_o,
  input wire logic [3:0] mem_clk_o,
  input wire logic [2:0] cpu_clk_o,
  input wire logic [7:0] mem_cmd_i,
  input wire logic [7:0] mem_cmd_o,
  input wire logic       locked_o,
  input wire logic       meas_miss_o,
  input wire logic [6:0] advance_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // step position mirrors the internal phase
  logic [6:0] cnt;
  logic [6:0] core_pos;
  logic [6:0] mem_pos;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) cnt <= 7'h00;
    else cnt <= cnt + 7'h01;
  end
  assign core_pos = cnt - 7'h01;
  assign mem_pos  = core_pos + advance_o;
  sequence s_core_rise;
    $rose(core_clk_o);
  endsequence
  a_core_clk_shape: assert property (core_clk_o == (core_pos < 7'h40))
    else $error("core clock shape wrong");
  a_mem_clk_lead: assert property (mem_clk_o[0] == (mem_pos < 7'h40))
    else $error("memory clock lead wrong");
  a_mem_clks_same: assert property (mem_clk_o == {4{fb_launch_o}})
    else $error("memory clocks differ from launch");
  a_cpu_follows_mem: assert property (cpu_clk_o == {3{mem_clk_o[0]}})
    else $error("cpu clocks differ");
  a_cmd_loads_core: assert property (s_core_rise |-> mem_cmd_o == $past(mem_cmd_i))
    else $error("command not loaded at core edge");
  a_cmd_holds_between: assert property (!$rose(core_clk_o) |-> $stable(mem_cmd_o))
    else $error("command moved off core edge");
  a_lock_stays_set: assert property (locked_o |=> locked_o)
    else $error("lock dropped");
  a_miss_keeps_adv: assert property ($rose(meas_miss_o) |-> $stable(advance_o) ##1 $stable(advance_o))
    else $error("advance moved on timeout");
  a_adv_needs_lock: assert property ($changed(advance_o) |-> locked_o)
    else $error("advance moved before lock");
endmodule // mcd_deskew_chk

bind mcd_deskew_dll mcd_deskew_chk u_chk (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .fb_launch_o(fb_launch_o),
  .core_clk_o(core_clk_o), .mem_clk_o(mem_clk_o), .cpu_clk_o(cpu_clk_o),
  .mem_cmd_i(mem_cmd_i), .mem_cmd_o(mem_cmd_o), .locked_o(locked_o),
  .meas_miss_o(meas_miss_o), .advance_o(advance_o)
);

//--- verif/mcd_deskew_dll_tb.sv
// self-checking bench for the memory clock deskew generator
`timescale 1ns/1ns
module mcd_deskew_dll_tb;
  typedef struct packed {
    logic [6:0] dly;
    logic [7:0] cmd;
    logic [6:0] adv;
  } mcd_row_t;
  logic       mclk_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       fb_launch_o;
  logic       fb_return_i;
  logic       core_clk_o;
  logic [3:0] mem_clk_o;
  logic [2:0] cpu_clk_o;
  logic [7:0] mem_cmd_i = 8'h00;
  logic [7:0] mem_cmd_o;
  logic       locked_o;
  logic       meas_miss_o;
  logic [6:0] advance_o;
  logic [6:0] dly = 7'h01;
  int         miscompares = 0;
  int         n_checks = 0;
  mcd_row_t   rows [4] = '{'{7'h01, 8'hA5, 7'h01}, '{7'h14, 8'h3C, 7'h14},
                           '{7'h40, 8'hFF, 7'h40}, '{7'h70, 8'h5A, 7'h70}};
  mcd_deskew_dll uut (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .fb_launch_o(fb_launch_o),
    .fb_return_i(fb_return_i), .core_clk_o(core_clk_o), .mem_clk_o(mem_clk_o),
    .cpu_clk_o(cpu_clk_o), .mem_cmd_i(mem_cmd_i), .mem_cmd_o(mem_cmd_o),
    .locked_o(locked_o), .meas_miss_o(meas_miss_o), .advance_o(advance_o)
  );
  mcd_fb_loop u_loop (
    .mclk_i(mclk_i), .launch_i(fb_launch_o), .delay_i(dly), .ret_o(fb_return_i)
  );
  initial begin
    forever #10 mclk_i = ~mclk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_periods(input int n);
    repeat (n * 128) @(negedge mclk_i);
  endtask
  initial begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (12) @(negedge mclk_i);
    check({locked_o, meas_miss_o, advance_o, core_clk_o, mem_clk_o}, 32'h0);
    check({cpu_clk_o, fb_launch_o, mem_cmd_o}, 32'h0);
    resetn_i = 1'b1;
    foreach (rows[i]) begin
      dly = rows[i].dly;
      mem_cmd_i = rows[i].cmd;
      wait_periods(5);
      check(advance_o, rows[i].adv);
      check({locked_o, meas_miss_o}, 2'b10);
      check(mem_cmd_o, rows[i].cmd);
    end
    // broken trace: timeout must keep the last advance
    dly = 7'h00;
    wait_periods(3);
    check({locked_o, meas_miss_o, advance_o}, {2'b11, 7'h70});
    dly = 7'h0A;
    wait_periods(5);
    check({meas_miss_o, advance_o}, {1'b0, 7'h0A});
    // second reset in mid-run clears lock and advance
    resetn_i = 1'b0;
    @(negedge mclk_i);
    check({locked_o, advance_o}, 8'h00);
    resetn_i = 1'b1;
    wait_periods(5);
    check({locked_o, advance_o}, {1'b1, 7'h0A});
    stop_test();
  end
endmodule // mcd_deskew_dll_tb
